// >>> hdl/emc_bus.sv
/*
 * External memory bus interface: data port carrying the low byte in the address phase, low, high and
 * extended address ports, page and extended address registers.
 * Assumes the core issues one access at a time and waits for done,
 * and that the external device holds read data for the whole strobe.
 * Register bus writes land on the next edge; a mode change made
 * during an access shows at the next idle cycle or take.
 * The legacy ports are never driven here, so their owner may use them.
 */
`timescale 1ns/100ps

module emc_bus (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Core access request and answer
	input emc_pkg::emc_req_type i_req,
	output logic o_busy,
	output logic o_done,
	output logic [7:0] o_rdata,
	// Special register bus
	input emc_pkg::emc_sfr_type i_sfr,
	output logic [7:0] o_sfr_rdata,
	output logic o_sfr_hit,
	// External data port input
	input wire logic [7:0] i_data_in,
	// External bus pins
	output emc_pkg::emc_pins_type o_pins,
	// Legacy ports 0 and 2 released for general use
	output logic o_legacy_ports_free
);
	import emc_pkg::*;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ADDR,
		ST_STROBE,
		ST_DONE
	} emc_state_type;

	typedef struct packed {
		// Sequencer
		emc_state_type st;
		logic [CNT_W-1:0] cnt;
		// Captured request
		emc_kind_type kind;
		logic write;
		logic [7:0] wdata;
		// Registered pin image
		emc_pins_type pins;
		// Register file
		logic [7:0] page;
		logic [7:0] ext_reg;
		// Answers to the core
		logic [7:0] sfr_rdata;
		logic sfr_hit;
		logic busy;
		logic done;
		logic [7:0] rdata;
		// Data port synchroniser
		logic [7:0] sync1;
		logic [7:0] sync2;
		// Legacy port flag
		logic legacy_free;
	} emc_regs_type;

	emc_regs_type cur_ff;
	emc_regs_type nxt_ff;

	// Data moves are the only kinds that use the RAM strobes
	function automatic logic external_data_move_instr_kind(input emc_kind_type kind);
		external_data_move_instr_kind = (kind == EMC_EXTERNAL_DATA_MOVE_INSTR_DPTR || kind == EMC_EXTERNAL_DATA_MOVE_INSTR_RI);
	endfunction : external_data_move_instr_kind

	// Register-indirect moves take the page byte, all else the core's
	function automatic logic [7:0] high_byte(input emc_kind_type kind,
		input logic [15:0] addr, input logic [7:0] page);
		if (kind == EMC_EXTERNAL_DATA_MOVE_INSTR_RI) begin
			high_byte = page;
		end else begin
			high_byte = addr[15:8];
		end
	endfunction : high_byte

	// Bank bits appear only for table reads and data moves, never fetches
	function automatic logic bank_kind(input emc_kind_type kind);
		bank_kind = (kind != EMC_FETCH);
	endfunction : bank_kind

	// True when the register bus hits one of this block's addresses
	function automatic logic sfr_mapped(input logic [7:0] addr);
		sfr_mapped = (addr == SFR_PAGE_ADDR || addr == SFR_EXT_ADDR);
	endfunction : sfr_mapped

	// Reserved bits are stored as ones on every write and forced again on every read
	function automatic logic [7:0] ext_store(input logic [7:0] wdata);
		ext_store = (wdata & EXT_STORE_MASK) | EXT_RSVD_ONES;
	endfunction : ext_store

	// Read value for a register bus read; unmapped addresses read zero
	function automatic logic [7:0] sfr_read(input logic [7:0] addr,
		input logic [7:0] page, input logic [7:0] ext_reg);
		if (addr == SFR_PAGE_ADDR) begin
			sfr_read = page;
		end else if (addr == SFR_EXT_ADDR) begin
			sfr_read = ext_reg | EXT_RSVD_ONES;
		end else begin
			sfr_read = BYTE_ZERO;
		end
	endfunction : sfr_read

	// Phase counters load length minus one and end at zero
	function automatic logic phase_end(input logic [CNT_W-1:0] cnt);
		phase_end = (cnt == CNT_ZERO);
	endfunction : phase_end

	// Counters only step down inside a phase, so no wrap can occur
	function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] cnt);
		count_down = cnt - CNT_W'(1);
	endfunction : count_down

	// Chip select pattern: the select matching high bits 7:6 is low
	function automatic logic [3:0] cs_decode(input logic [7:0] high);
		cs_decode = ~(CS_ONE << high[7:6]);
	endfunction : cs_decode

	// Extended port value for the given high address and bank phase
	function automatic logic [3:0] ext_drive(input logic [7:0] ext_reg,
		input logic [7:0] high, input logic bank_phase);
		if (ext_reg[EXT_MODE_BIT]) begin
			ext_drive = cs_decode(high);
		end else if (bank_phase) begin
			ext_drive = ext_reg[3:0];
		end else begin
			ext_drive = EXT_ZERO;
		end
	endfunction : ext_drive

	// Access walk: take, two address cycles with the low byte on the
	// data port, four strobe cycles, strobes rise, then one hold cycle
	// with data still driven before done pulses and the port is released.
	// Read data is taken late by the synchroniser depth, so the strobe
	// must outlast it.
	always_comb begin
		logic [7:0] high;
		logic bank;
		logic is_external_data_move_instr;
		high = BYTE_ZERO;
		bank = 1'b0;
		is_external_data_move_instr = 1'b0;
		// Per-cycle defaults: pulses drop unless a state raises them
		nxt_ff = cur_ff;
		nxt_ff.done = 1'b0;
		nxt_ff.legacy_free = 1'b1;
		// Pin data crosses two flops before anything reads it
		nxt_ff.sync1 = i_data_in;
		nxt_ff.sync2 = cur_ff.sync1;

		// Special register writes; bus writes are rare next to accesses
		if (i_sfr.wr && i_sfr.addr == SFR_PAGE_ADDR) begin
			nxt_ff.page = i_sfr.wdata;
		end
		if (i_sfr.wr && i_sfr.addr == SFR_EXT_ADDR) begin
			nxt_ff.ext_reg = ext_store(i_sfr.wdata);
		end
		// Answer is registered one cycle after the read strobe
		nxt_ff.sfr_hit = i_sfr.rd && sfr_mapped(i_sfr.addr);
		if (i_sfr.rd) begin
			nxt_ff.sfr_rdata = sfr_read(i_sfr.addr, cur_ff.page, cur_ff.ext_reg);
		end else begin
			nxt_ff.sfr_rdata = BYTE_ZERO;
		end

		// Access sequencer
		unique case (cur_ff.st)
			ST_IDLE: begin
				nxt_ff.busy = 1'b0;
				// Idle: addresses stay, bank output returns to zero
				nxt_ff.pins.ext_addr = ext_drive(cur_ff.ext_reg,
					cur_ff.pins.high_addr, 1'b0);
				if (i_req.valid) begin
					// Take: every address pin is set in one edge and then held
					high = high_byte(i_req.kind, i_req.addr, cur_ff.page);
					bank = bank_kind(i_req.kind);
					nxt_ff.st = ST_ADDR;
					nxt_ff.cnt = ADDR_CNT;
					nxt_ff.busy = 1'b1;
					nxt_ff.kind = i_req.kind;
					nxt_ff.write = i_req.write && external_data_move_instr_kind(i_req.kind);
					nxt_ff.wdata = i_req.wdata;
					nxt_ff.pins.low_addr = i_req.addr[7:0];
					nxt_ff.pins.high_addr = high;
					nxt_ff.pins.ext_addr = ext_drive(cur_ff.ext_reg, high, bank);
					nxt_ff.pins.data_out = i_req.addr[7:0];
					nxt_ff.pins.data_oe = 1'b1;
				end
			end

			ST_ADDR: begin
				if (phase_end(cur_ff.cnt)) begin
					// Strobes fall only after the address has settled
					is_external_data_move_instr = external_data_move_instr_kind(cur_ff.kind);
					nxt_ff.st = ST_STROBE;
					nxt_ff.cnt = STROBE_CNT;
					nxt_ff.pins.program_store_enable_n = is_external_data_move_instr;
					nxt_ff.pins.rd_n = !(is_external_data_move_instr && !cur_ff.write);
					nxt_ff.pins.wr_n = !(is_external_data_move_instr && cur_ff.write);
					nxt_ff.pins.data_out = cur_ff.wdata;
					nxt_ff.pins.data_oe = cur_ff.write;
				end else begin
					nxt_ff.cnt = count_down(cur_ff.cnt);
				end
			end

			ST_STROBE: begin
				if (phase_end(cur_ff.cnt)) begin
					// Synchronised data lags the pin by two cycles
					nxt_ff.rdata = cur_ff.sync2;
					nxt_ff.st = ST_DONE;
					// Strobes rise together; data stays driven one more cycle
					nxt_ff.pins.program_store_enable_n = 1'b1;
					nxt_ff.pins.rd_n = 1'b1;
					nxt_ff.pins.wr_n = 1'b1;
				end else begin
					nxt_ff.cnt = count_down(cur_ff.cnt);
				end
			end

			ST_DONE: begin
				// Data released one cycle after strobes rise: hold time
				nxt_ff.pins.data_oe = 1'b0;
				nxt_ff.done = 1'b1;
				nxt_ff.busy = 1'b0;
				nxt_ff.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			// Sequencer and captured request
			cur_ff.st <= ST_IDLE;
			cur_ff.cnt <= CNT_ZERO;
			cur_ff.kind <= EMC_FETCH;
			cur_ff.write <= 1'b0;
			cur_ff.wdata <= BYTE_ZERO;

			// Pins idle: strobes high, data port released
			cur_ff.pins.data_out <= BYTE_ZERO;
			cur_ff.pins.data_oe <= 1'b0;
			cur_ff.pins.low_addr <= BYTE_ZERO;
			cur_ff.pins.high_addr <= BYTE_ZERO;
			cur_ff.pins.ext_addr <= EXT_ZERO;
			cur_ff.pins.program_store_enable_n <= 1'b1;
			cur_ff.pins.rd_n <= 1'b1;
			cur_ff.pins.wr_n <= 1'b1;

			// Register file
			cur_ff.page <= PAGE_RESET;
			cur_ff.ext_reg <= EXT_RESET;

			// Answers to the core
			cur_ff.sfr_rdata <= BYTE_ZERO;
			cur_ff.sfr_hit <= 1'b0;
			cur_ff.busy <= 1'b0;
			cur_ff.done <= 1'b0;
			cur_ff.rdata <= BYTE_ZERO;

			// Synchroniser and legacy flag
			cur_ff.sync1 <= BYTE_ZERO;
			cur_ff.sync2 <= BYTE_ZERO;
			cur_ff.legacy_free <= 1'b0;
		end else begin
			cur_ff <= nxt_ff;
		end
	end

	// Every output is a flop of the state image
	assign o_busy = cur_ff.busy;
	assign o_done = cur_ff.done;
	assign o_rdata = cur_ff.rdata;
	assign o_sfr_rdata = cur_ff.sfr_rdata;
	assign o_sfr_hit = cur_ff.sfr_hit;
	assign o_pins = cur_ff.pins;
	assign o_legacy_ports_free = cur_ff.legacy_free;

endmodule : emc_bus

// >>> hdl/emc_pkg.sv
/*
 * Constants, register map and carrier types for the external memory
 * address and chip select block.
 * Assumes a 100 MHz core clock and an 8-bit special register bus.
 */
package emc_pkg;

	// Clock
	localparam int CLK_PERIOD_NS = 10;

	// Access phase times and their cycle counts, least times rounded up
	localparam int ADDR_TIME_NS = 20;
	localparam int STROBE_TIME_NS = 40;
	localparam int ADDR_CYCLES = (ADDR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYCLES = (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] ADDR_CNT = CNT_W'(ADDR_CYCLES - 1);
	localparam logic [CNT_W-1:0] STROBE_CNT = CNT_W'(STROBE_CYCLES - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

	// Special register addresses
	localparam logic [7:0] SFR_PAGE_ADDR = 8'ha1;
	localparam logic [7:0] SFR_EXT_ADDR = 8'ha2;

	// Reset values
	localparam logic [7:0] PAGE_RESET = 8'h00;
	localparam logic [7:0] EXT_RESET = 8'h70;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Extended address register fields
	localparam int EXT_MODE_BIT = 7;
	localparam logic [7:0] EXT_RSVD_ONES = 8'h70;
	localparam logic [7:0] EXT_STORE_MASK = 8'h8f;
	localparam logic [3:0] EXT_ZERO = 4'h0;
	localparam logic [3:0] CS_NONE = 4'hf;
	localparam logic [3:0] CS_ONE = 4'h1;

	// Kinds of external access requested by the core
	typedef enum logic [1:0] {
		EMC_FETCH,
		EMC_CODE_TABLE,
		EMC_EXTERNAL_DATA_MOVE_INSTR_DPTR,
		EMC_EXTERNAL_DATA_MOVE_INSTR_RI
	} emc_kind_type;

	// Access request from the core
	typedef struct packed {
		logic valid;
		emc_kind_type kind;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} emc_req_type;

	// Special register bus from the core
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} emc_sfr_type;

	// External bus pins driven by the block
	typedef struct packed {
		logic [7:0] data_out;
		logic data_oe;
		logic [7:0] low_addr;
		logic [7:0] high_addr;
		logic [3:0] ext_addr;
		logic program_store_enable_n;
		logic rd_n;
		logic wr_n;
	} emc_pins_type;

endpackage : emc_pkg

// >>> test/emc_bus_chk_sva.sv
/* Assertions on emc_bus pins and register port.
   Assumes one access at a time and no mode change mid access. */
`timescale 1ns/100ps
module emc_bus_chk
	import emc_pkg::*;
(
	// Watched ports
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input emc_pkg::emc_req_type i_req,
	input emc_pkg::emc_sfr_type i_sfr,
	input wire logic o_busy,
	input wire logic o_done,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_sfr_hit,
	input emc_pkg::emc_pins_type o_pins
);
	emc_req_type cur_ff;
	logic [7:0] pg_ff;
	logic [7:0] ext_ff;
	logic [7:0] hi;
	logic stb;
	assign stb = !(o_pins.program_store_enable_n && o_pins.rd_n && o_pins.wr_n);
	assign hi = cur_ff.kind == EMC_EXTERNAL_DATA_MOVE_INSTR_RI ? pg_ff : cur_ff.addr[15:8];
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			cur_ff <= '0;
			pg_ff <= 8'h00;
			ext_ff <= 8'h70;
		end else begin
			if (i_req.valid && !o_busy) cur_ff <= i_req;
			if (i_sfr.wr && i_sfr.addr == 8'ha1) pg_ff <= i_sfr.wdata;
			if (i_sfr.wr && i_sfr.addr == 8'ha2) ext_ff <= i_sfr.wdata | 8'h70;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	a_done_lat: assert property (i_req.valid && !o_busy |-> ##[7:8] o_done)
		else $error("done late");
	a_low_addr: assert property (stb |-> o_pins.low_addr == cur_ff.addr[7:0])
		else $error("low addr");
	a_high_addr: assert property (stb |-> o_pins.high_addr == hi)
		else $error("high addr");
	a_data_mux: assert property (stb && !$past(stb) |->
		$past(o_pins.data_oe) && $past(o_pins.data_out) == cur_ff.addr[7:0])
		else $error("addr phase");
	a_ext_bank: assert property (stb && !ext_ff[7] |->
		o_pins.ext_addr == (cur_ff.kind == EMC_FETCH ? 4'h0 : ext_ff[3:0]))
		else $error("bank bits");
	a_chip_sel: assert property (stb && ext_ff[7] |->
		o_pins.ext_addr == ~(4'h1 << o_pins.high_addr[7:6]))
		else $error("chip select");
	a_addr_hold: assert property (stb && $past(stb) |->
		$stable({o_pins.low_addr, o_pins.high_addr, o_pins.ext_addr}))
		else $error("addr moved");
	a_strobe_kind: assert property (stb |-> o_pins.program_store_enable_n == cur_ff.kind[1] &&
		o_pins.wr_n == !(cur_ff.kind[1] && cur_ff.write))
		else $error("strobe kind");
	a_sfr_read: assert property (i_sfr.rd && i_sfr.addr == 8'ha2 |=>
		o_sfr_hit && o_sfr_rdata == $past(ext_ff))
		else $error("ext reg read");
endmodule : emc_bus_chk

// >>> test/emc_mem.sv
/* External memory model answering strobes with an address-derived byte.
   Assumes pins come straight from emc_bus. */
`timescale 1ns/100ps
module emc_mem (
	// Clock and pins
	input wire logic i_clk,
	input emc_pkg::emc_pins_type i_pins,
	// Data port and last written byte
	output logic [7:0] o_data,
	output logic [7:0] o_wr_data
);
	import emc_pkg::*;
	logic [7:0] last_ff = 8'h00;
	// Released bus toggles so a late sample cannot pass by chance
	assign o_data = (!i_pins.program_store_enable_n || !i_pins.rd_n) ?
		i_pins.low_addr ^ i_pins.high_addr ^ {4'h0, i_pins.ext_addr} : ~last_ff;
	always_ff @(posedge i_clk) begin
		last_ff <= o_data;
		if (!i_pins.wr_n) begin
			o_wr_data <= i_pins.data_out;
		end
	end
endmodule : emc_mem

// >>> test/ext_mem_address_chip_select_test.sv
/* Directed bench for emc_bus: register port, every access kind, both port modes.
   Assumes emc_mem answers the strobes. */
`timescale 1ns/100ps
module ext_mem_address_chip_select_test;
	import emc_pkg::*;
	logic i_clk, i_sys_rst, o_busy, o_done, o_sfr_hit, o_legacy_ports_free;
	emc_req_type i_req;
	emc_sfr_type i_sfr;
	emc_pins_type o_pins;
	logic [7:0] o_rdata, o_sfr_rdata, i_data_in, wr_data;
	int n_fail = 0;
	int samples_checked = 0;
	emc_bus DUT (.*);
	emc_mem u_mem (.i_clk(i_clk), .i_pins(o_pins), .o_data(i_data_in), .o_wr_data(wr_data));
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask : chk
	task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d);
		i_sfr = '{w, !w, a, d};
		@(posedge i_clk);
		#1 i_sfr = '0;
		if (!w) chk("sfr", d, o_sfr_rdata);
		if (!w) chk("hit", {7'h0, a != 8'ha3}, {7'h0, o_sfr_hit});
	endtask : sfr
	task automatic acc(input int k, input logic w, input logic [15:0] a,
		input logic [7:0] h, input logic [3:0] x);
		i_req = '{1'b1, emc_kind_type'(k), w, a, 8'hc3};
		@(posedge i_clk);
		#1 i_req.valid = 1'b0;
		chk("busy", 8'h01, {7'h0, o_busy});
		for (int i = 0; i < 12 && o_done !== 1'b1; i++) begin
			@(posedge i_clk);
			#1;
		end
		chk("done", 8'h01, {7'h0, o_done});
		if (w) chk("written", 8'hc3, wr_data);
		else chk("read", a[7:0] ^ h ^ {4'h0, x}, o_rdata);
	endtask : acc
	task automatic conclude();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Span is many times the expected run
	initial begin
		#100000;
		n_fail++;
		conclude();
	end
	initial begin
		logic [7:0] pg, h;
		logic [15:0] a;
		logic [3:0] x;
		i_sys_rst = 1'b1;
		i_req = '0;
		i_sfr = '0;
		repeat (16) @(posedge i_clk);
		#1 i_sys_rst = 1'b0;
		sfr(0, 8'ha2, 8'h70);
		sfr(0, 8'ha1, 8'h00);
		sfr(0, 8'ha3, 8'h00);
		chk("legacy", 8'h01, {7'h0, o_legacy_ports_free});
		for (int m = 0; m < 2; m++) begin
			pg = m ? 8'hc5 : 8'h5a;
			sfr(1, 8'ha1, pg);
			sfr(1, 8'ha2, m ? 8'h80 : 8'h0b);
			sfr(1, 8'ha3, 8'hff);
			sfr(0, 8'ha2, m ? 8'hf0 : 8'h7b);
			sfr(0, 8'ha1, pg);
			for (int k = 0; k < 4; k++) begin
				a = {k[1:0], 14'h0a5c};
				h = k == 3 ? pg : a[15:8];
				x = m ? ~(4'h1 << h[7:6]) : (k == 0 ? 4'h0 : 4'hb);
				acc(k, 1'b0, a, h, x);
				if (k > 1) acc(k, 1'b1, a, h, x);
			end
		end
		conclude();
	end
endmodule : ext_mem_address_chip_select_test
bind emc_bus emc_bus_chk u_chk (.*);
